//--- rtl/amc_pkg.sv
package amc_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [6:0] AMC_IDX_LEFT_ATTENUATION = 7'h10;
  localparam logic [6:0] AMC_IDX_RIGHT_ATTENUATION = 7'h11;
  localparam logic [6:0] AMC_IDX_FORMAT_DEEMPH_MUTE_CTRL = 7'h12;
  localparam logic [6:0] AMC_IDX_OUTPUT_FILTER_CTRL = 7'h13;
  localparam logic [6:0] AMC_IDX_SYSTEM_MODE_CTRL = 7'h14;
  localparam logic [6:0] AMC_IDX_ZERO_OUTPUT_CTRL = 7'h15;
  localparam logic [6:0] AMC_IDX_ZERO_FLAG_STATUS = 7'h16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] AMC_RST_ATTENUATION = 8'hff;
  localparam logic [7:0] AMC_RST_FORMAT_DEEMPH_MUTE_CTRL = 8'h50;
  localparam logic [7:0] AMC_RST_OUTPUT_FILTER_CTRL = 8'h00;
  localparam logic [7:0] AMC_RST_SYSTEM_MODE_CTRL = 8'h00;
  localparam logic [7:0] AMC_RST_ZERO_OUTPUT_CTRL = 8'h01;

  // ----------------------------------------------------------------
  // Writable bits of the system mode and zero output registers; the rest are reserved
  // ----------------------------------------------------------------
  localparam logic [7:0] AMC_MASK_SYSTEM_MODE_CTRL = 8'h7f;
  localparam logic [7:0] AMC_MASK_ZERO_OUTPUT_CTRL = 8'h07;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AMC_POS_ATTEN_LOAD_ENABLE = 7;
  localparam int AMC_POS_INPUT_FORMAT_SELECT = 4;
  localparam int AMC_POS_DEEMPH_RATE_SELECT = 2;
  localparam int AMC_POS_DEEMPH_ENABLE = 1;
  localparam int AMC_POS_SOFT_MUTE = 0;
  localparam int AMC_POS_PHASE_REVERSE = 7;
  localparam int AMC_POS_ATTEN_SPEED_SELECT = 5;
  localparam int AMC_POS_CONVERTER_OPERATION_CTRL = 4;
  localparam int AMC_POS_ZERO_PIN_FUNCTION_SELECT = 3;
  localparam int AMC_POS_BYPASS_STEREO_SELECT = 2;
  localparam int AMC_POS_ROLLOFF_SELECT = 1;
  localparam int AMC_POS_INFINITE_ZERO_MUTE_ENABLE = 0;
  localparam int AMC_POS_SOFT_SYSTEM_RESET = 6;
  localparam int AMC_POS_BITSTREAM_MODE = 5;
  localparam int AMC_POS_FILTER_BYPASS_ENABLE = 4;
  localparam int AMC_POS_MONO_MODE = 3;
  localparam int AMC_POS_MONO_CHANNEL_SELECT = 2;
  localparam int AMC_POS_OVERSAMPLE_RATE_SELECT = 0;
  localparam int AMC_POS_BITSTREAM_ZERO_OUT_ENABLE = 1;
  localparam int AMC_POS_PCM_ZERO_OUT_ENABLE = 0;
  localparam int AMC_POS_RIGHT_ZERO_FLAG = 1;
  localparam int AMC_POS_LEFT_ZERO_FLAG = 0;

  // ----------------------------------------------------------------
  // Attenuation codes and soft mute ramp
  // ----------------------------------------------------------------
  localparam logic [7:0] AMC_ATTEN_MUTE_MAX_CODE = 8'h0e;
  localparam logic [7:0] AMC_ATTEN_FULL_SCALE = 8'hff;
  localparam logic [7:0] AMC_RAMP_MUTED_LEVEL = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AMC_FMT_RJ16 = 3'h0,
    AMC_FMT_RJ20 = 3'h1,
    AMC_FMT_RJ24 = 3'h2,
    AMC_FMT_LJ24 = 3'h3,
    AMC_FMT_I2S16 = 3'h4,
    AMC_FMT_I2S24 = 3'h5,
    AMC_FMT_RSV6 = 3'h6,
    AMC_FMT_RSV7 = 3'h7
  } amc_format_type;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] half_db;
    logic muted;
  } amc_atten_type;

  typedef struct packed {
    amc_format_type input_format_select;
    logic format_reserved;
    logic [1:0] deemph_rate_select;
    logic [1:0] fir_performance_select;
    logic deemph_enable;
    logic soft_mute;
    logic phase_reverse;
    logic [1:0] atten_speed_select;
    logic converter_operation_ctrl;
    logic zero_pin_function_select;
    logic bypass_stereo_select;
    logic rolloff_select;
    logic infinite_zero_mute_enable;
    logic bitstream_mode;
    logic filter_bypass_enable;
    logic mono_mode;
    logic mono_channel_select;
    logic [1:0] oversample_rate_select;
    logic [1:0] fir_rate_select;
    logic pcm_zero_out_enable;
    logic [1:0] bitstream_zero_out_enable;
  } amc_mode_type;

  typedef enum logic [2:0] {
    AMC_RAMP_HOLD = 3'b001,
    AMC_RAMP_DOWN = 3'b010,
    AMC_RAMP_UP = 3'b100
  } amc_ramp_state_type;

endpackage

//--- rtl/amc_mode_control_bank.sv
module amc_mode_control_bank
  import amc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_index,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sample_tick,
  input wire logic left_zero_detect,
  input wire logic right_zero_detect,
  output amc_mode_type mode_out,
  output amc_atten_type left_atten_out,
  output amc_atten_type right_atten_out,
  output logic soft_reset_pulse
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic amc_atten_type atten_decode(input logic [7:0] code);
    amc_atten_type res;
    res.code = code;
    res.muted = (code <= AMC_ATTEN_MUTE_MAX_CODE);
    res.half_db = AMC_ATTEN_FULL_SCALE - code;
    return res;
  endfunction

  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    return (a < b) ? a : b;
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] left_atten_level_reg;
  logic [7:0] left_atten_level_next;
  logic [7:0] right_atten_level_reg;
  logic [7:0] right_atten_level_next;
  logic [7:0] format_deemph_mute_ctrl_reg;
  logic [7:0] format_deemph_mute_ctrl_next;
  logic [7:0] output_filter_ctrl_reg;
  logic [7:0] output_filter_ctrl_next;
  logic [7:0] system_mode_ctrl_reg;
  logic [7:0] system_mode_ctrl_next;
  logic [7:0] zero_output_ctrl_reg;
  logic [7:0] zero_output_ctrl_next;
  logic [7:0] zero_flag_status_reg;
  logic [7:0] zero_flag_status_next;
  logic [7:0] applied_left_reg;
  logic [7:0] applied_left_next;
  logic [7:0] applied_right_reg;
  logic [7:0] applied_right_next;
  logic [7:0] reg_rdata_next;
  logic soft_reset_pulse_reg;
  logic soft_reset_pulse_next;
  logic atten_load_enable;
  logic soft_reset_req;

  assign atten_load_enable = format_deemph_mute_ctrl_reg[AMC_POS_ATTEN_LOAD_ENABLE];
  // A write of the soft reset bit restores every setting at once; the bit itself reads back as normal operation.
  assign soft_reset_req = reg_wr_en && (reg_index == AMC_IDX_SYSTEM_MODE_CTRL)
    && reg_wdata[AMC_POS_SOFT_SYSTEM_RESET];

  always_comb begin
    left_atten_level_next = left_atten_level_reg;
    right_atten_level_next = right_atten_level_reg;
    format_deemph_mute_ctrl_next = format_deemph_mute_ctrl_reg;
    output_filter_ctrl_next = output_filter_ctrl_reg;
    system_mode_ctrl_next = system_mode_ctrl_reg;
    zero_output_ctrl_next = zero_output_ctrl_reg;
    applied_left_next = applied_left_reg;
    applied_right_next = applied_right_reg;
    soft_reset_pulse_next = 1'b0;
    if (soft_reset_req) begin
      left_atten_level_next = AMC_RST_ATTENUATION;
      right_atten_level_next = AMC_RST_ATTENUATION;
      format_deemph_mute_ctrl_next = AMC_RST_FORMAT_DEEMPH_MUTE_CTRL;
      output_filter_ctrl_next = AMC_RST_OUTPUT_FILTER_CTRL;
      system_mode_ctrl_next = AMC_RST_SYSTEM_MODE_CTRL;
      zero_output_ctrl_next = AMC_RST_ZERO_OUTPUT_CTRL;
      applied_left_next = AMC_RST_ATTENUATION;
      applied_right_next = AMC_RST_ATTENUATION;
      soft_reset_pulse_next = 1'b1;
    end else if (reg_wr_en) begin
      unique case (reg_index)
        AMC_IDX_LEFT_ATTENUATION: begin
          left_atten_level_next = reg_wdata;
          if (atten_load_enable) begin
            applied_left_next = reg_wdata;
          end
        end
        AMC_IDX_RIGHT_ATTENUATION: begin
          right_atten_level_next = reg_wdata;
          if (atten_load_enable) begin
            applied_right_next = reg_wdata;
          end
        end
        AMC_IDX_FORMAT_DEEMPH_MUTE_CTRL: begin
          format_deemph_mute_ctrl_next = reg_wdata;
        end
        AMC_IDX_OUTPUT_FILTER_CTRL: begin
          output_filter_ctrl_next = reg_wdata;
        end
        AMC_IDX_SYSTEM_MODE_CTRL: begin
          system_mode_ctrl_next = reg_wdata & AMC_MASK_SYSTEM_MODE_CTRL;
        end
        AMC_IDX_ZERO_OUTPUT_CTRL: begin
          zero_output_ctrl_next = reg_wdata & AMC_MASK_ZERO_OUTPUT_CTRL;
        end
        default: begin
          // The zero flag register and unmapped indices ignore writes.
          left_atten_level_next = left_atten_level_reg;
        end
      endcase
    end
  end

  always_comb begin
    zero_flag_status_next = 8'h00;
    zero_flag_status_next[AMC_POS_LEFT_ZERO_FLAG] = left_zero_detect;
    zero_flag_status_next[AMC_POS_RIGHT_ZERO_FLAG] = right_zero_detect;
  end

  always_comb begin
    reg_rdata_next = reg_rdata;
    if (reg_rd_en) begin
      unique case (reg_index)
        AMC_IDX_LEFT_ATTENUATION: reg_rdata_next = left_atten_level_reg;
        AMC_IDX_RIGHT_ATTENUATION: reg_rdata_next = right_atten_level_reg;
        AMC_IDX_FORMAT_DEEMPH_MUTE_CTRL: reg_rdata_next = format_deemph_mute_ctrl_reg;
        AMC_IDX_OUTPUT_FILTER_CTRL: reg_rdata_next = output_filter_ctrl_reg;
        AMC_IDX_SYSTEM_MODE_CTRL: reg_rdata_next = system_mode_ctrl_reg;
        AMC_IDX_ZERO_OUTPUT_CTRL: reg_rdata_next = zero_output_ctrl_reg;
        AMC_IDX_ZERO_FLAG_STATUS: reg_rdata_next = zero_flag_status_reg;
        default: reg_rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      left_atten_level_reg <= AMC_RST_ATTENUATION;
      right_atten_level_reg <= AMC_RST_ATTENUATION;
      format_deemph_mute_ctrl_reg <= AMC_RST_FORMAT_DEEMPH_MUTE_CTRL;
      output_filter_ctrl_reg <= AMC_RST_OUTPUT_FILTER_CTRL;
      system_mode_ctrl_reg <= AMC_RST_SYSTEM_MODE_CTRL;
      zero_output_ctrl_reg <= AMC_RST_ZERO_OUTPUT_CTRL;
      zero_flag_status_reg <= 8'h00;
      applied_left_reg <= AMC_RST_ATTENUATION;
      applied_right_reg <= AMC_RST_ATTENUATION;
      reg_rdata <= 8'h00;
      soft_reset_pulse_reg <= 1'b0;
    end else begin
      left_atten_level_reg <= left_atten_level_next;
      right_atten_level_reg <= right_atten_level_next;
      format_deemph_mute_ctrl_reg <= format_deemph_mute_ctrl_next;
      output_filter_ctrl_reg <= output_filter_ctrl_next;
      system_mode_ctrl_reg <= system_mode_ctrl_next;
      zero_output_ctrl_reg <= zero_output_ctrl_next;
      zero_flag_status_reg <= zero_flag_status_next;
      applied_left_reg <= applied_left_next;
      applied_right_reg <= applied_right_next;
      reg_rdata <= reg_rdata_next;
      soft_reset_pulse_reg <= soft_reset_pulse_next;
    end
  end

  assign soft_reset_pulse = soft_reset_pulse_reg;

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  amc_mode_type mode_next;
  amc_mode_type mode_reg;

  always_comb begin
    mode_next.input_format_select = amc_format_type'(
      format_deemph_mute_ctrl_reg[AMC_POS_INPUT_FORMAT_SELECT +: 3]);
    mode_next.format_reserved = format_deemph_mute_ctrl_reg[AMC_POS_INPUT_FORMAT_SELECT + 2]
      && format_deemph_mute_ctrl_reg[AMC_POS_INPUT_FORMAT_SELECT + 1];
    mode_next.bitstream_mode = system_mode_ctrl_reg[AMC_POS_BITSTREAM_MODE];
    // The shared two-bit fields are steered to one meaning or the other so downstream never sees both.
    mode_next.deemph_rate_select = mode_next.bitstream_mode ? 2'h0
      : format_deemph_mute_ctrl_reg[AMC_POS_DEEMPH_RATE_SELECT +: 2];
    mode_next.fir_performance_select = mode_next.bitstream_mode
      ? format_deemph_mute_ctrl_reg[AMC_POS_DEEMPH_RATE_SELECT +: 2] : 2'h0;
    mode_next.deemph_enable = format_deemph_mute_ctrl_reg[AMC_POS_DEEMPH_ENABLE];
    mode_next.soft_mute = format_deemph_mute_ctrl_reg[AMC_POS_SOFT_MUTE];
    mode_next.phase_reverse = output_filter_ctrl_reg[AMC_POS_PHASE_REVERSE];
    mode_next.atten_speed_select = output_filter_ctrl_reg[AMC_POS_ATTEN_SPEED_SELECT +: 2];
    mode_next.converter_operation_ctrl = output_filter_ctrl_reg[AMC_POS_CONVERTER_OPERATION_CTRL];
    mode_next.zero_pin_function_select = output_filter_ctrl_reg[AMC_POS_ZERO_PIN_FUNCTION_SELECT];
    mode_next.bypass_stereo_select = output_filter_ctrl_reg[AMC_POS_BYPASS_STEREO_SELECT];
    mode_next.rolloff_select = output_filter_ctrl_reg[AMC_POS_ROLLOFF_SELECT];
    mode_next.infinite_zero_mute_enable = output_filter_ctrl_reg[AMC_POS_INFINITE_ZERO_MUTE_ENABLE];
    mode_next.filter_bypass_enable = system_mode_ctrl_reg[AMC_POS_FILTER_BYPASS_ENABLE];
    mode_next.mono_mode = system_mode_ctrl_reg[AMC_POS_MONO_MODE];
    mode_next.mono_channel_select = system_mode_ctrl_reg[AMC_POS_MONO_CHANNEL_SELECT];
    mode_next.oversample_rate_select = mode_next.bitstream_mode ? 2'h0
      : system_mode_ctrl_reg[AMC_POS_OVERSAMPLE_RATE_SELECT +: 2];
    mode_next.fir_rate_select = mode_next.bitstream_mode
      ? system_mode_ctrl_reg[AMC_POS_OVERSAMPLE_RATE_SELECT +: 2] : 2'h0;
    mode_next.pcm_zero_out_enable = zero_output_ctrl_reg[AMC_POS_PCM_ZERO_OUT_ENABLE];
    mode_next.bitstream_zero_out_enable = zero_output_ctrl_reg[AMC_POS_BITSTREAM_ZERO_OUT_ENABLE +: 2];
  end

  // ----------------------------------------------------------------
  // Soft mute ramp
  // ----------------------------------------------------------------
  amc_ramp_state_type ramp_state_reg;
  amc_ramp_state_type ramp_state_next;
  logic [7:0] ramp_level_reg;
  logic [7:0] ramp_level_next;
  logic [2:0] ramp_div_reg;
  logic [2:0] ramp_div_next;
  logic [2:0] ramp_div_limit;
  logic ramp_step;
  amc_atten_type left_atten_next;
  amc_atten_type right_atten_next;

  // A step every 1, 2, 4 or 8 sample ticks.
  assign ramp_div_limit = 3'((4'h1 << mode_reg.atten_speed_select) - 4'h1);
  assign ramp_step = sample_tick && (ramp_div_reg >= ramp_div_limit);

  always_comb begin
    ramp_state_next = ramp_state_reg;
    ramp_level_next = ramp_level_reg;
    ramp_div_next = ramp_div_reg;
    if (sample_tick) begin
      ramp_div_next = ramp_step ? 3'h0 : 3'(ramp_div_reg + 3'h1);
    end
    unique case (ramp_state_reg)
      AMC_RAMP_HOLD: begin
        if (mode_reg.soft_mute && (ramp_level_reg != AMC_RAMP_MUTED_LEVEL)) begin
          ramp_state_next = AMC_RAMP_DOWN;
        end else if (!mode_reg.soft_mute && (ramp_level_reg != AMC_ATTEN_FULL_SCALE)) begin
          ramp_state_next = AMC_RAMP_UP;
        end
      end
      AMC_RAMP_DOWN: begin
        if (!mode_reg.soft_mute) begin
          ramp_state_next = AMC_RAMP_UP;
        end else if (ramp_step) begin
          ramp_level_next = 8'(ramp_level_reg - 8'h01);
          if (ramp_level_reg == 8'h01) begin
            ramp_state_next = AMC_RAMP_HOLD;
          end
        end
      end
      AMC_RAMP_UP: begin
        if (mode_reg.soft_mute) begin
          ramp_state_next = AMC_RAMP_DOWN;
        end else if (ramp_step) begin
          ramp_level_next = 8'(ramp_level_reg + 8'h01);
          if (ramp_level_reg == 8'hfe) begin
            ramp_state_next = AMC_RAMP_HOLD;
          end
        end
      end
      default: begin
        ramp_state_next = AMC_RAMP_HOLD;
      end
    endcase
    // The ramp is a ceiling on the applied code, so a muted channel always reaches the mute codes.
    left_atten_next = atten_decode(min8(applied_left_reg, ramp_level_reg));
    right_atten_next = atten_decode(min8(applied_right_reg, ramp_level_reg));
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ramp_state_reg <= AMC_RAMP_HOLD;
      ramp_level_reg <= AMC_ATTEN_FULL_SCALE;
      ramp_div_reg <= 3'h0;
      mode_reg <= '0;
      left_atten_out <= '0;
      right_atten_out <= '0;
    end else begin
      ramp_state_reg <= ramp_state_next;
      ramp_level_reg <= ramp_level_next;
      ramp_div_reg <= ramp_div_next;
      mode_reg <= mode_next;
      left_atten_out <= left_atten_next;
      right_atten_out <= right_atten_next;
    end
  end

  assign mode_out = mode_reg;

endmodule

//--- verification/amc_mode_control_bank_monitor.sv
module amc_mode_control_bank_monitor
  import amc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic sample_tick,
  input wire logic left_zero_detect,
  input wire logic right_zero_detect,
  input wire amc_mode_type mode_out,
  input wire amc_atten_type left_atten_out,
  input wire amc_atten_type right_atten_out,
  input wire logic soft_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Register port and decoded output checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic wr_ctl;
  logic mode_wr;
  logic rd_ctl;
  logic mapped;
  assign wr_ctl = reg_wr_en && reg_index == AMC_IDX_OUTPUT_FILTER_CTRL;
  assign rd_ctl = reg_rd_en && !reg_wr_en && reg_index == AMC_IDX_OUTPUT_FILTER_CTRL;
  assign mode_wr = reg_wr_en && (reg_index == AMC_IDX_OUTPUT_FILTER_CTRL || reg_index == AMC_IDX_SYSTEM_MODE_CTRL);
  assign mapped = reg_index >= AMC_IDX_LEFT_ATTENUATION && reg_index <= AMC_IDX_ZERO_FLAG_STATUS;
  sequence s_ctl_write;
    wr_ctl;
  endsequence
  sequence s_quiet;
    (!mode_wr)[*3];
  endsequence
  a_unmapped_read_zero: assert property (reg_rd_en && !reg_wr_en && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_flag_read_live: assert property (reg_rd_en && !reg_wr_en && reg_index == AMC_IDX_ZERO_FLAG_STATUS
    && $stable(left_zero_detect) && $stable(right_zero_detect)
    |=> reg_rdata == {6'h00, $past(right_zero_detect), $past(left_zero_detect)})
    else $error("zero flag read wrong");
  a_ctl_read_back: assert property (s_ctl_write ##1 !reg_wr_en ##1 rd_ctl |=> reg_rdata == $past(reg_wdata, 3))
    else $error("control register readback wrong");
  a_ctl_mode_follow: assert property (s_ctl_write ##1 s_quiet |->
    {mode_out.phase_reverse, mode_out.atten_speed_select, mode_out.infinite_zero_mute_enable}
    == {$past(reg_wdata[7], 3), $past(reg_wdata[6:5], 3), $past(reg_wdata[0], 3)})
    else $error("mode output does not follow write");
  a_reset_pulse_due: assert property (reg_wr_en && reg_index == AMC_IDX_SYSTEM_MODE_CTRL && reg_wdata[6]
    |-> ##[1:2] soft_reset_pulse)
    else $error("soft reset pulse missing");
  a_reset_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  a_atten_decode_ok: assert property ($past(rstn) |-> left_atten_out.half_db == 8'hff - left_atten_out.code
    && left_atten_out.muted == (left_atten_out.code <= AMC_ATTEN_MUTE_MAX_CODE)
    && right_atten_out.half_db == 8'hff - right_atten_out.code
    && right_atten_out.muted == (right_atten_out.code <= AMC_ATTEN_MUTE_MAX_CODE))
    else $error("attenuation decode wrong");
  a_fmt_reserved_flag: assert property (mode_out.format_reserved
    == (mode_out.input_format_select inside {AMC_FMT_RSV6, AMC_FMT_RSV7}))
    else $error("reserved format flag wrong");
  a_bitstream_field_swap: assert property (mode_out.bitstream_mode
    ? (mode_out.deemph_rate_select == 2'h0 && mode_out.oversample_rate_select == 2'h0)
    : (mode_out.fir_performance_select == 2'h0 && mode_out.fir_rate_select == 2'h0))
    else $error("bitstream field routing wrong");
  a_rdata_holds_idle: assert property (!reg_rd_en && !reg_wr_en && !soft_reset_pulse |=> $stable(reg_rdata))
    else $error("read data changed without read");
endmodule

bind amc_mode_control_bank amc_mode_control_bank_monitor amc_mode_control_bank_monitor_i (
  .core_clk(core_clk), .rstn(rstn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_index(reg_index),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_tick(sample_tick), .left_zero_detect(left_zero_detect),
  .right_zero_detect(right_zero_detect), .mode_out(mode_out), .left_atten_out(left_atten_out),
  .right_atten_out(right_atten_out), .soft_reset_pulse(soft_reset_pulse));

//--- verification/amc_host_model.sv
module amc_host_model
  import amc_pkg::*;
(
  input wire logic core_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [6:0] reg_index,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Host side of the register port
  // ----------------------------------------------------------------
  // Between accesses index and data show the inverse of the last value,
  // so a design that samples them late never sees a plausible leftover.
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_index = 7'h00;
    reg_wdata = 8'h00;
  end
  task automatic write_reg(input logic [6:0] idx, input logic [7:0] data);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_index <= idx;
    reg_wdata <= data;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_index <= ~idx;
    reg_wdata <= ~data;
  endtask
  task automatic read_reg(input logic [6:0] idx, output logic [7:0] data);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_index <= idx;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    reg_index <= ~idx;
    #1 data = reg_rdata;
  endtask
endmodule

//--- verification/amc_mode_control_bank_tb.sv
module amc_mode_control_bank_tb
  import amc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  logic core_clk, rstn, reg_wr_en, reg_rd_en, sample_tick, left_zero_detect, right_zero_detect, soft_reset_pulse;
  logic [6:0] reg_index;
  logic [7:0] reg_wdata, reg_rdata, d, c;
  amc_mode_type mode_out;
  amc_atten_type left_atten_out, right_atten_out;
  int err_total = 0;
  int num_checks = 0;
  int pulse_cnt = 0;
  logic [6:0] idx_tab [9] = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h7f};
  logic [7:0] def_tab [9] = '{8'hff, 8'hff, 8'h50, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0] code_tab [4] = '{8'h00, 8'h0e, 8'h0f, 8'h80};
  amc_mode_control_bank amc_mode_control_bank_i (.core_clk(core_clk), .rstn(rstn), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_tick(sample_tick), .left_zero_detect(left_zero_detect), .right_zero_detect(right_zero_detect),
    .mode_out(mode_out), .left_atten_out(left_atten_out), .right_atten_out(right_atten_out),
    .soft_reset_pulse(soft_reset_pulse));
  amc_host_model amc_host_model_i (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  // A sample every other clock keeps the mute ramps short but still slower than the clock.
  always @(posedge core_clk) sample_tick <= ~sample_tick;
  always @(posedge core_clk) if (soft_reset_pulse === 1'b1) pulse_cnt++;
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #300us;
    err_total++;
    close_out();
  end
  initial begin
    rstn = 1'b0;
    sample_tick = 1'b0;
    left_zero_detect = 1'b0;
    right_zero_detect = 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    wait_cyc(2);
    for (int i = 0; i < 9; i++) begin
      amc_host_model_i.read_reg(idx_tab[i], d);
      check(d, def_tab[i]);
    end
    check({mode_out.input_format_select, mode_out.pcm_zero_out_enable, left_atten_out.code}, {AMC_FMT_I2S24, 9'h1ff});
    $display("test defaults done");
    for (int i = 0; i < 2; i++) begin
      c = i ? 8'h5a : 8'ha5;
      // Reading one idle cycle after the write exercises the readback sequence that a_ctl_read_back checks as well.
      amc_host_model_i.write_reg(7'h13, c);
      amc_host_model_i.read_reg(7'h13, d);
      check(d, c);
      wait_cyc(3);
      check({mode_out.phase_reverse, mode_out.atten_speed_select, mode_out.converter_operation_ctrl,
        mode_out.zero_pin_function_select, mode_out.bypass_stereo_select, mode_out.rolloff_select,
        mode_out.infinite_zero_mute_enable}, c);
    end
    amc_host_model_i.write_reg(7'h14, 8'ha3);
    amc_host_model_i.write_reg(7'h12, 8'h58);
    amc_host_model_i.read_reg(7'h14, d);
    check(d, 8'h23);
    check({mode_out.fir_rate_select, mode_out.oversample_rate_select, mode_out.fir_performance_select}, 6'h32);
    amc_host_model_i.write_reg(7'h14, 8'h1f);
    amc_host_model_i.write_reg(7'h15, 8'hff);
    amc_host_model_i.read_reg(7'h15, d);
    check(d, 8'h07);
    check({mode_out.filter_bypass_enable, mode_out.mono_mode, mode_out.mono_channel_select,
      mode_out.oversample_rate_select, mode_out.fir_rate_select, mode_out.bitstream_zero_out_enable}, 9'h1f3);
    for (int i = 0; i < 8; i++) begin
      amc_host_model_i.write_reg(7'h12, {1'b0, i[2:0], i[1:0], 2'b10});
      wait_cyc(3);
      check({mode_out.input_format_select, mode_out.format_reserved}, {i[2:0], i >= 6});
      check({mode_out.deemph_rate_select, mode_out.deemph_enable, mode_out.soft_mute}, {i[1:0], 2'b10});
    end
    $display("test mode fields done");
    amc_host_model_i.write_reg(7'h12, 8'h00);
    amc_host_model_i.write_reg(7'h10, 8'h20);
    amc_host_model_i.write_reg(7'h12, 8'h80);
    amc_host_model_i.read_reg(7'h10, d);
    check({d, left_atten_out.code}, 16'h20ff);
    for (int k = 0; k < 4; k++) begin
      c = code_tab[k];
      amc_host_model_i.write_reg(7'h10, c);
      amc_host_model_i.write_reg(7'h11, ~c);
      wait_cyc(3);
      check({left_atten_out.code, left_atten_out.half_db, left_atten_out.muted}, {c, 8'hff - c, c <= 8'h0e});
      check({right_atten_out.code, right_atten_out.half_db}, {~c, c});
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      {right_zero_detect, left_zero_detect} <= i[1:0];
      wait_cyc(3);
      amc_host_model_i.write_reg(7'h16, 8'hff);
      amc_host_model_i.read_reg(7'h16, d);
      check(d, {6'h00, i[1:0]});
    end
    $display("test attenuation and flags done");
    amc_host_model_i.write_reg(7'h10, 8'hff);
    for (int s = 0; s < 2; s++) begin
      amc_host_model_i.write_reg(7'h13, {1'b0, s[1:0], 5'h00});
      amc_host_model_i.write_reg(7'h12, 8'h81);
      wait_cyc(600);
      check(left_atten_out.code === 8'h00, s == 0);
      wait_cyc(600);
      check({left_atten_out.code, left_atten_out.muted}, 9'h001);
      amc_host_model_i.write_reg(7'h12, 8'h80);
      wait_cyc(1200);
      check(left_atten_out.code, 8'hff);
    end
    $display("test soft mute done");
    amc_host_model_i.write_reg(7'h14, 8'h40);
    wait_cyc(4);
    check(pulse_cnt, 1);
    for (int i = 0; i < 6; i++) begin
      amc_host_model_i.read_reg(idx_tab[i], d);
      check(d, def_tab[i]);
    end
    $display("test soft reset done");
    close_out();
  end
endmodule
